/* pcg_map.svh */
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
// Register reset values
`define PCG_DIR_RST      8'hff
`define PCG_LAT_RST      8'h00
`define PCG_ANSEL_RST    8'hfc
`define PCG_ANSEL_MASK   8'hfc
`define PCG_FUSE_RST     8'hff
// Fuse byte field positions
`define PCG_FUSE_PWM2B   5
`define PCG_FUSE_TMR3    4
`define PCG_FUSE_CMP3    2
`define PCG_FUSE_CMP2    0
// Pin positions of remappable and oscillator functions
`define PCG_PIN_TMR3     0
`define PCG_PIN_CMP2     1
`define PCG_PIN_CMP1     2
`define PCG_PIN_SCLK     3
`define PCG_PIN_SDAT     4
`define PCG_PIN_SDO      5
`define PCG_PIN_CMP3     6
`define PCG_PIN_RXDT     7
`define PCG_SOSC_MASK    8'h03
`endif

/* pcg_pin_model.sv */
`timescale 1ns/1ps
// Outside circuit: a resistive source per pin that the port's driver overrides
module pcg_pin_model (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] pinIn
);
  // Released pins fall to the pulled level, never to a stale driven one
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : pcg_pin_model

/* pcg_pkg.sv */
package pcg_pkg;
  // One digital output function: enable and level
  typedef struct packed {
    logic en;
    logic val;
  } pcg_drv_t;

  // Function that owns the pin direction while enabled
  typedef struct packed {
    logic own;
    logic oe;
    logic val;
  } pcg_ovr_t;

  // Output requests of the internal peripherals
  typedef struct packed {
    pcg_drv_t pwmTwoChannelB;
    pcg_drv_t pwmTwoChannelA;
    pcg_drv_t captureCompareTwoPin;
    pcg_drv_t chargeTimePulseOut;
    pcg_drv_t pwmOneChannelA;
    pcg_drv_t captureCompareOnePin;
    pcg_drv_t captureCompareThreePin;
    pcg_ovr_t syncSerialClock;
    pcg_ovr_t syncSerialData;
    pcg_ovr_t syncSerialDataOut;
    pcg_ovr_t serialTransceiverTx;
    pcg_ovr_t serialTransceiverDt;
    logic     secondaryOscEn;
  } pcg_periph_out_t;

  // Pin levels delivered to the internal peripherals
  typedef struct packed {
    logic timerThreeClockIn;
    logic timerThreeGateIn;
    logic timerOneClockIn;
    logic timerFiveClockIn;
    logic captureOneIn;
    logic captureTwoIn;
    logic captureThreeIn;
    logic serialOneSpiClockIn;
    logic serialOneSpiDataIn;
    logic serialOneI2cClockIn;
    logic serialOneI2cDataIn;
    logic transceiverRxIn;
    logic transceiverDtIn;
  } pcg_periph_in_t;

  // Relocated outputs leaving for the other ports
  typedef struct packed {
    pcg_drv_t portBBitThree;
    pcg_drv_t portEBitZero;
    pcg_drv_t pwmTwoBDefault;
    pcg_drv_t ccpThreeDefault;
  } pcg_reloc_t;
endpackage : pcg_pkg

/* pcg_port.sv */
// How it works
// - eight pins, each with direction, latch, readback
// - direction bit 1 turns the driver off
// - direction bit 0 drives the latch out
// - latch reads back latch, not pin levels
// - timer three clock: bit 0, else port B
// - capture/compare two: bit 1, else port B
// - cleared fuses bring PWM2B here, and compare three here unless LARGE_PART (then port E)
// - serial peripherals override the pin direction
// - power-on reset makes analog pins analog inputs
// - direction read returns stored bits despite overrides
// - highest priority output function owns the pin
// - analog inputs get pins only when selected
// - digital outputs still drive pins in analog mode
// - analog mode disables the digital input path
// - latch output unaffected by analog mode
// - bits 1 and 0 have no analog select
// - bit 1: compare out or capture in
// - bit 2: compare out or capture in
// - bit 3: serial clock out or in
// - bit 4 feeds SPI data in as input
// - oscillator takes bits 0, 1 regardless of direction
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_port #(
  parameter bit LARGE_PART = 1'b0
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire logic                     dirWrEn,
  input  wire logic [7:0]               dirWrData,
  input  wire logic                     latWrEn,
  input  wire logic [7:0]               latWrData,
  input  wire logic                     anselWrEn,
  input  wire logic [7:0]               anselWrData,
  input  wire logic [7:0]               fuseConfigByte,
  output logic      [7:0]               portCDir,
  output logic      [7:0]               portCOutLatch,
  output logic      [7:0]               portCAnalogSelect,
  output logic      [7:0]               portCPinValue,
  input  wire logic [7:0]               pinIn,
  output logic      [7:0]               pinOut,
  output logic      [7:0]               pinOe,
  output logic      [7:0]               analogConnect,
  output logic      [1:0]               secondaryOscConnect,
  input  wire logic                     portBBitFiveIn,
  input  wire logic                     portBBitThreeIn,
  input  wire logic                     portEBitZeroIn,
  input  wire pcg_pkg::pcg_periph_out_t periphOut,
  output pcg_pkg::pcg_periph_in_t       periphIn,
  output pcg_pkg::pcg_reloc_t           relocOut
);
  logic       rstMetaReg;
  logic       rstnSafe;
  logic [7:0] dirReg;
  logic [7:0] latReg;
  logic [7:0] anselReg;
  logic [7:0] fuseReg;
  logic       fuseLoadedReg;
  logic [7:0] pinValueReg;
  logic [7:0] pinOutReg;
  logic [7:0] pinOeReg;
  logic [7:0] pinOut_next;
  logic [7:0] pinOe_next;
  logic [10:0] syncedIn;
  logic [7:0] pinSync;
  logic       portB5Sync;
  logic       portB3Sync;
  logic       portE0Sync;
  logic [7:0] ovrOwn;
  logic [7:0] ovrOe;
  logic [7:0] ovrVal;
  logic [7:0] fnEn;
  logic [7:0] fnVal;
  logic [7:0] oscHold;
  logic [7:0] digIn;
  wire        pwm2bHere;
  wire        tmr3Here;
  wire        cmp2Here;
  wire        cmp3Here;
  wire        cmp3OnPortE;

  if (LARGE_PART !== 1'b0 && LARGE_PART !== 1'b1) begin : gBadPart
    $error("pcg_port: LARGE_PART must be 0 or 1");
  end

  // Reset asserts at once and releases after two clean edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMetaReg <= 1'b0;
      rstnSafe   <= 1'b0;
    end else begin
      rstMetaReg <= 1'b1;
      rstnSafe   <= rstMetaReg;
    end
  end

  // Pin and foreign-port levels are asynchronous to clk
  pcg_sync #(
    .WIDTH (11)
  ) uSync (
    .clk     (clk),
    .rstn    (rstnSafe),
    .ce      (ce),
    .asyncIn ({portEBitZeroIn, portBBitThreeIn, portBBitFiveIn, pinIn}),
    .syncOut (syncedIn)
  );
  assign pinSync    = syncedIn[7:0];
  assign portB5Sync = syncedIn[8];
  assign portB3Sync = syncedIn[9];
  assign portE0Sync = syncedIn[10];

  // Direction register, all inputs after reset
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      dirReg <= `PCG_DIR_RST;
    end else if (ce && dirWrEn) begin
      dirReg <= dirWrData;
    end
  end

  // Output latch, kept apart from the pin levels
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      latReg <= `PCG_LAT_RST;
    end else if (ce && latWrEn) begin
      latReg <= latWrData;
    end
  end

  // Analog select; the two low bits do not exist
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      anselReg <= `PCG_ANSEL_RST;
    end else if (ce && anselWrEn) begin
      anselReg <= anselWrData & `PCG_ANSEL_MASK;
    end
  end

  // Fuses are caught once after reset release, not under reset,
  // so a strap change later has no effect until the next reset
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      fuseReg       <= `PCG_FUSE_RST;
      fuseLoadedReg <= 1'b0;
    end else if (ce && !fuseLoadedReg) begin
      fuseReg       <= fuseConfigByte;
      fuseLoadedReg <= 1'b1;
    end
  end

  // Readback: stored contents, never the overridden direction
  assign portCDir          = dirReg;
  assign portCOutLatch     = latReg;
  assign portCAnalogSelect = anselReg;
  assign portCPinValue     = pinValueReg;

  // Fuse decode: a cleared fuse selects the alternate pin
  assign pwm2bHere   = ~fuseReg[`PCG_FUSE_PWM2B];
  assign tmr3Here    = fuseReg[`PCG_FUSE_TMR3];
  assign cmp2Here    = fuseReg[`PCG_FUSE_CMP2];
  assign cmp3OnPortE = ~fuseReg[`PCG_FUSE_CMP3] & LARGE_PART;
  assign cmp3Here    = ~fuseReg[`PCG_FUSE_CMP3] & ~LARGE_PART;

  // Oscillator pins ignore the direction bits entirely
  assign oscHold = periphOut.secondaryOscEn ? `PCG_SOSC_MASK : 8'h00;
  assign secondaryOscConnect = {2{periphOut.secondaryOscEn}};

  // Serial peripherals that take over the direction bit
  assign ovrOwn = {periphOut.serialTransceiverDt.own,
                   periphOut.serialTransceiverTx.own,
                   periphOut.syncSerialDataOut.own,
                   periphOut.syncSerialData.own,
                   periphOut.syncSerialClock.own,
                   3'h0};
  assign ovrOe  = {periphOut.serialTransceiverDt.oe,
                   periphOut.serialTransceiverTx.oe,
                   periphOut.syncSerialDataOut.oe,
                   periphOut.syncSerialData.oe,
                   periphOut.syncSerialClock.oe,
                   3'h0};
  assign ovrVal = {periphOut.serialTransceiverDt.val,
                   periphOut.serialTransceiverTx.val,
                   periphOut.syncSerialDataOut.val,
                   periphOut.syncSerialData.val,
                   periphOut.syncSerialClock.val,
                   3'h0};

  // Direction-gated functions, already resolved by pin priority
  assign fnEn[0] = pwm2bHere & periphOut.pwmTwoChannelB.en;
  assign fnVal[0] = periphOut.pwmTwoChannelB.val;
  // Bit 1: PWM channel A ahead of compare two
  assign fnEn[1] = periphOut.pwmTwoChannelA.en
                 | (cmp2Here & periphOut.captureCompareTwoPin.en);
  assign fnVal[1] = periphOut.pwmTwoChannelA.en ? periphOut.pwmTwoChannelA.val
                  : periphOut.captureCompareTwoPin.val;
  // Bit 2: pulse generator, then PWM channel A, then compare one
  assign fnEn[2] = periphOut.chargeTimePulseOut.en
                 | periphOut.pwmOneChannelA.en
                 | periphOut.captureCompareOnePin.en;
  assign fnVal[2] = periphOut.chargeTimePulseOut.en ? periphOut.chargeTimePulseOut.val
                  : periphOut.pwmOneChannelA.en ? periphOut.pwmOneChannelA.val
                  : periphOut.captureCompareOnePin.val;
  assign fnEn[5:3]  = 3'h0;
  assign fnVal[5:3] = 3'h0;
  // Bit 6: compare three only when relocated here
  assign fnEn[6] = cmp3Here & periphOut.captureCompareThreePin.en;
  assign fnVal[6] = periphOut.captureCompareThreePin.val;
  assign fnEn[7]  = 1'b0;
  assign fnVal[7] = 1'b0;

  // Per-pin driver and input path
  for (genvar i = 0; i < 8; i++) begin : gPin
    wire driveOut;
    // Override beats the direction bit; the oscillator beats both
    assign driveOut = ~oscHold[i] & (ovrOwn[i] ? ovrOe[i] : ~dirReg[i]);
    assign pinOe_next[i] = driveOut;
    // Analog select plays no part here, so digital outputs
    // keep the pin in analog mode with the usual priority
    assign pinOut_next[i] = ~driveOut ? 1'b0
                          : ovrOwn[i] ? ovrVal[i]
                          : fnEn[i]   ? fnVal[i]
                          : latReg[i];
    // Digital input buffer is cut in analog mode and reads 0
    assign digIn[i] = pinSync[i] & ~anselReg[i] & ~oscHold[i];
  end

  // Analog functions reach a pin only when it is selected
  assign analogConnect = anselReg;

  // Pin drivers and readback come from flops to keep them glitch-free
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      pinOutReg   <= 8'h00;
      pinOeReg    <= 8'h00;
      pinValueReg <= 8'h00;
    end else if (ce) begin
      pinOutReg   <= pinOut_next;
      pinOeReg    <= pinOe_next;
      pinValueReg <= digIn;
    end
  end
  assign pinOut = pinOutReg;
  assign pinOe  = pinOeReg;

  // Inputs handed to the peripherals; capture paths need input direction
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      periphIn <= '0;
    end else if (ce) begin
      periphIn.timerThreeClockIn   <= tmr3Here ? digIn[`PCG_PIN_TMR3] : portB5Sync;
      periphIn.timerThreeGateIn    <= digIn[`PCG_PIN_TMR3];
      periphIn.timerOneClockIn     <= digIn[`PCG_PIN_TMR3];
      periphIn.timerFiveClockIn    <= digIn[`PCG_PIN_CMP1];
      periphIn.captureOneIn        <= digIn[`PCG_PIN_CMP1] & dirReg[`PCG_PIN_CMP1];
      periphIn.captureTwoIn        <= cmp2Here ? digIn[`PCG_PIN_CMP2] & dirReg[`PCG_PIN_CMP2]
                                    : portB3Sync;
      periphIn.captureThreeIn      <= cmp3OnPortE ? portE0Sync
                                    : digIn[`PCG_PIN_CMP3] & dirReg[`PCG_PIN_CMP3];
      periphIn.serialOneSpiClockIn <= digIn[`PCG_PIN_SCLK] & ~pinOe_next[`PCG_PIN_SCLK];
      periphIn.serialOneI2cClockIn <= digIn[`PCG_PIN_SCLK];
      periphIn.serialOneSpiDataIn  <= digIn[`PCG_PIN_SDAT] & dirReg[`PCG_PIN_SDAT];
      periphIn.serialOneI2cDataIn  <= digIn[`PCG_PIN_SDAT];
      periphIn.transceiverRxIn     <= digIn[`PCG_PIN_RXDT];
      periphIn.transceiverDtIn     <= digIn[`PCG_PIN_RXDT];
    end
  end

  // Relocated outputs for the neighbouring ports
  always_ff @(posedge clk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      relocOut <= '0;
    end else if (ce) begin
      relocOut.portBBitThree.en    <= ~cmp2Here & periphOut.captureCompareTwoPin.en;
      relocOut.portBBitThree.val   <= periphOut.captureCompareTwoPin.val;
      relocOut.portEBitZero.en     <= cmp3OnPortE & periphOut.captureCompareThreePin.en;
      relocOut.portEBitZero.val    <= periphOut.captureCompareThreePin.val;
      relocOut.pwmTwoBDefault.en   <= ~pwm2bHere & periphOut.pwmTwoChannelB.en;
      relocOut.pwmTwoBDefault.val  <= periphOut.pwmTwoChannelB.val;
      relocOut.ccpThreeDefault.en  <= fuseReg[`PCG_FUSE_CMP3] & periphOut.captureCompareThreePin.en;
      relocOut.ccpThreeDefault.val <= periphOut.captureCompareThreePin.val;
    end
  end
endmodule : pcg_port

/* pcg_port_sva.sv */
`timescale 1ns/1ps
module pcg_port_sva (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire logic                     dirWrEn,
  input  wire logic [7:0]               dirWrData,
  input  wire logic                     latWrEn,
  input  wire logic [7:0]               latWrData,
  input  wire logic [7:0]               portCDir,
  input  wire logic [7:0]               portCOutLatch,
  input  wire logic [7:0]               portCAnalogSelect,
  input  wire logic [7:0]               portCPinValue,
  input  wire logic [7:0]               pinIn,
  input  wire logic [7:0]               pinOut,
  input  wire logic [7:0]               pinOe,
  input  wire logic [1:0]               secondaryOscConnect,
  input  wire pcg_pkg::pcg_periph_out_t periphOut
);
  logic [2:0] relCnt;
  wire        up = (relCnt == 3'h7);
  // Edges since release; the internal reset copy lags the pin
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) relCnt <= 3'h0;
    else if (!up) relCnt <= relCnt + 3'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Reset state, port ownership and writes
  reset_state_a: assert property ($rose(rstn) |-> portCDir == 8'hff && portCAnalogSelect == 8'hfc && pinOe == 8'h00)
    else $error("bad state after reset");
  dir_write_a: assert property (up && ce && dirWrEn |=> portCDir == $past(dirWrData))
    else $error("direction write lost");
  lat_write_a: assert property (up && ce && latWrEn |=> portCOutLatch == $past(latWrData))
    else $error("latch write lost");
  ansel_low_a: assert property (portCAnalogSelect[1:0] == 2'h0)
    else $error("analog select low bits set");
  input_off_a: assert property (ce && portCDir[2] |=> !pinOe[2])
    else $error("input pin driven");
  latch_drive_a: assert property (ce && !portCDir[4] && !periphOut.syncSerialData.own
    |=> pinOe[4] && pinOut[4] == $past(portCOutLatch[4]))
    else $error("latch not driven");
  serial_override_a: assert property (up && ce && periphOut.serialTransceiverTx.own
    |=> pinOe[6] == $past(periphOut.serialTransceiverTx.oe))
    else $error("serial override ignored");
  osc_pins_a: assert property (ce && periphOut.secondaryOscEn
    |-> secondaryOscConnect == 2'h3 ##1 pinOe[1:0] == 2'h0)
    else $error("oscillator pins not released");
  analog_read_a: assert property (up && ce && portCAnalogSelect[5] |=> !portCPinValue[5])
    else $error("analog pin reads high");
  pin_sample_a: assert property ((up && ce && pinIn[7] && !portCAnalogSelect[7])[*3] |=> portCPinValue[7])
    else $error("pin level not sampled");

  // Main scenarios reached
  cover property ($rose(rstn));
  cover property (ce && periphOut.serialTransceiverTx.own);
  cover property (ce && periphOut.secondaryOscEn);
endmodule : pcg_port_sva

bind pcg_port pcg_port_sva i_sva (.clk(clk), .rstn(rstn), .ce(ce), .dirWrEn(dirWrEn), .dirWrData(dirWrData),
  .latWrEn(latWrEn), .latWrData(latWrData), .portCDir(portCDir), .portCOutLatch(portCOutLatch),
  .portCAnalogSelect(portCAnalogSelect), .portCPinValue(portCPinValue), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .secondaryOscConnect(secondaryOscConnect), .periphOut(periphOut));

/* pcg_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin levels
module pcg_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOneReg;

  if (WIDTH < 1) begin : gBadWidth
    $error("pcg_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage, never logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stageOneReg <= '0;
      syncOut     <= '0;
    end else if (ce) begin
      stageOneReg <= asyncIn;
      syncOut     <= stageOneReg;
    end
  end
endmodule : pcg_sync

/* test_port_c_gpio_mux.sv */
`timescale 1ns/1ps
module test_port_c_gpio_mux;
  localparam logic [2:0] D = 3'h1;
  localparam logic [2:0] L = 3'h2;
  localparam logic [2:0] A = 3'h4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic dirWrEn = 1'b0, latWrEn = 1'b0, anselWrEn = 1'b0;
  logic [7:0] dirWrData = 8'h00, latWrData = 8'h00, anselWrData = 8'h00;
  logic [7:0] fuse = 8'hff, extLevel = 8'hbc;
  logic portB5 = 1'b1, portB3 = 1'b0, portE0 = 1'b0;
  logic [7:0] dir, lat, ansel, pinVal, pinIn, pinOut, pinOe, anaCon;
  logic [1:0] oscCon;
  pcg_pkg::pcg_periph_out_t po = '0;
  pcg_pkg::pcg_periph_in_t  pi;
  pcg_pkg::pcg_reloc_t      ro;
  int bad_count = 0;
  int check_count = 0;

  // 125 MHz clock
  initial forever #4 clk = ~clk;

  pcg_port i_dut (.clk(clk), .rstn(rstn), .ce(ce), .dirWrEn(dirWrEn), .dirWrData(dirWrData),
    .latWrEn(latWrEn), .latWrData(latWrData), .anselWrEn(anselWrEn), .anselWrData(anselWrData),
    .fuseConfigByte(fuse), .portCDir(dir), .portCOutLatch(lat), .portCAnalogSelect(ansel),
    .portCPinValue(pinVal), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .analogConnect(anaCon),
    .secondaryOscConnect(oscCon), .portBBitFiveIn(portB5), .portBBitThreeIn(portB3),
    .portEBitZeroIn(portE0), .periphOut(po), .periphIn(pi), .relocOut(ro));
  pcg_pin_model i_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write cycle; strobes m pick the registers
  task automatic wr(input logic [2:0] m, input logic [7:0] d);
    @(negedge clk);
    dirWrData = d;
    latWrData = d;
    anselWrData = d;
    {anselWrEn, latWrEn, dirWrEn} = m;
    @(negedge clk);
    {anselWrEn, latWrEn, dirWrEn} = 3'h0;
  endtask : wr

  // Covers output register, two sync stages and the read register
  task automatic wt;
    repeat (5) @(negedge clk);
  endtask : wt

  // Fuses are taken once after release, so a new fuse byte needs a reset
  task automatic do_reset(input logic [7:0] f);
    rstn = 1'b0;
    fuse = f;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    do_reset(8'hff);
    chk(dir, 8'hff);
    chk(ansel, 8'hfc);
    wr(A, 8'hff);
    chk(ansel, 8'hfc);
    $display("test reset done");
    wr(A, 8'h00);
    wr(L, 8'ha5);
    wr(D, 8'hf0);
    wt;
    chk(pinOe, 8'h0f);
    chk(pinOut, 8'h05);
    chk(pinVal, 8'hb5);
    wr(A, 8'hf0);
    wt;
    chk(pinVal, 8'h05);
    chk(anaCon, 8'hf0);
    chk(pinOut, 8'h05);
    wr(D, 8'h00);
    wt;
    chk(pinOut, 8'ha5);
    wr(D, 8'hff);
    wr(L, lat ^ 8'h01);
    chk(lat, 8'ha4);
    $display("test direction and analog done");
    po.serialTransceiverTx = 3'h7;
    po.syncSerialData = 3'h4;
    wr(D, 8'hef);
    wt;
    chk(pinOe, 8'h40);
    chk(dir, 8'hef);
    po.syncSerialClock = 3'h4;
    wr(A, 8'h00);
    wr(D, 8'hff);
    wt;
    chk(8'(pi.serialOneSpiClockIn), 8'h01);
    chk(8'(pi.serialOneSpiDataIn), 8'h01);
    chk(8'(pi.captureOneIn), 8'h01);
    chk(8'(pi.timerThreeClockIn), 8'h00);
    $display("test overrides done");
    po.pwmOneChannelA = 2'h2;
    po.captureCompareTwoPin = 2'h3;
    po.pwmTwoChannelB = 2'h3;
    wr(D, 8'h00);
    wt;
    chk(8'(pinOut[2:0]), 8'h02);
    chk(8'(ro.pwmTwoBDefault), 8'h03);
    // Unused alternate pin: enable low, level still follows the compare output
    chk(8'(ro.portBBitThree), 8'h01);
    po.chargeTimePulseOut = 2'h3;
    wt;
    chk(8'(pinOut[2:0]), 8'h06);
    po.secondaryOscEn = 1'b1;
    wt;
    chk(8'({pinOe[1:0], oscCon}), 8'h03);
    $display("test functions done");
    po = '0;
    do_reset(8'h00);
    po.pwmTwoChannelB = 2'h3;
    po.captureCompareThreePin = 2'h3;
    po.captureCompareTwoPin = 2'h3;
    wr(D, 8'h00);
    wt;
    chk(pinOut, 8'h41);
    chk(8'(ro.portBBitThree), 8'h03);
    chk(8'(pi.timerThreeClockIn), 8'h01);
    chk(8'(ro.ccpThreeDefault), 8'h01);
    chk(8'(ro.portEBitZero), 8'h01);
    // Clock enable low: a write and a function change must both be held off
    ce = 1'b0;
    po.pwmTwoChannelB = 2'h0;
    wr(D, 8'hff);
    wt;
    chk(dir, 8'h00);
    chk(pinOut, 8'h41);
    ce = 1'b1;
    $display("test remap done");
    final_report;
  end

  // Watchdog: the tests need some 100 cycles, so 3000 means a hang
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule : test_port_c_gpio_mux
